// *** src/upis_regs.svh ***
`ifndef UPIS_REGS_SVH
`define UPIS_REGS_SVH
// register indices; byte address is four times the index
`define UPIS_IDX_ADDR_A 8'h10
`define UPIS_IDX_PORT_SC 8'h1f
`define UPIS_IDX_ADDR_B 8'h40
`define UPIS_IDX_INT_EN 8'h20
`define UPIS_IDX_PENDING 8'h22
`define UPIS_IDX_PROC_SC 8'h23
`define UPIS_IDX_CS_EN 8'h24
`define UPIS_IDX_CS_POL 8'h25
`define UPIS_IDX_GP_EN 8'h26
`define UPIS_IDX_GP_POL 8'h27
`define UPIS_IDX_PINS 8'h28
// upstream port status and control fields
`define UPIS_SC_DP_BIT 5
`define UPIS_SC_DM_BIT 4
`define UPIS_SC_ACT_BIT 3
`define UPIS_SC_RESET 8'h00
`define UPIS_PROC_BUSRST_BIT 5
// pending / enable bit positions
`define UPIS_SRC_BUSRST 0
`define UPIS_SRC_T128 1
`define UPIS_SRC_T1024 2
`define UPIS_SRC_EP0 3
`define UPIS_SRC_CS 8
`define UPIS_SRC_GPIO 9
// timing
`define UPIS_CLK_PS 5000
`define UPIS_SE0_MIN_PS 12000000
`define UPIS_SE0_MAX_PS 16000000
`define UPIS_T128_PS 128000000
`define UPIS_T1024_PS 1024000000
`define UPIS_SE0_CYC ((`UPIS_SE0_MIN_PS + `UPIS_CLK_PS - 1) / `UPIS_CLK_PS)
`define UPIS_T128_CYC (`UPIS_T128_PS / `UPIS_CLK_PS)
`define UPIS_T1024_CYC (`UPIS_T1024_PS / `UPIS_CLK_PS)
`endif

// *** src/upis_pkg.sv ***
package upis_pkg;
   typedef enum logic [1:0] {
      UPIS_LINE_IDLE = 2'h0,
      UPIS_LINE_SE0 = 2'h1,
      UPIS_LINE_RESET = 2'h3
   } upis_line_t;

   typedef struct packed {
      logic drive;
      logic enable;
   } upis_pin_t;

   typedef struct packed {
      logic [7:0] addr_a;
      logic [7:0] addr_b;
      logic [7:0] port_sc;
      logic [9:0] int_en;
      logic [9:0] pending;
      logic busrst_seen;
      logic [7:0] cs_en;
      logic [7:0] cs_pol;
      logic [15:0] gp_en;
      logic [1:0] gp_pol;
   } upis_regs_t;
endpackage : upis_pkg

// *** src/upis_top.sv ***
// Our own choice: the Avalon-MM interface to the registers.
`include "upis_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module upis_top
   import upis_pkg::*;
#(
   parameter int T128_CYC = `UPIS_T128_CYC,
   parameter int T1024_CYC = `UPIS_T1024_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic dp_in,
   input wire logic dm_in,
   output logic dp_out,
   output logic dp_oe_out,
   output logic dm_out,
   output logic dm_oe_out,
   input wire logic sie_dp_in,
   input wire logic sie_dm_in,
   input wire logic sie_oe_in,
   input wire logic [4:0] ep_in_host_ack_in,
   input wire logic [4:0] ep_out_dev_ack_in,
   input wire logic [7:0] cs_pin_in,
   input wire logic [15:0] gp_pin_in,
   input wire logic startup_active_in,
   output logic startup_abort_out,
   input wire logic irq_ack_in,
   output logic irq_req_out,
   output logic [3:0] irq_vector_out
);
   localparam int SE0_CYC = `UPIS_SE0_CYC;
   localparam int NPIN = 24;

   // synchronisers; stage 1 feeds only stage 2
   // no reset: a zeroed chain would fake a line change and an SE0 right after reset
   logic [NPIN+1:0] sync1, sync2, sync3;
   always_ff @(posedge clk_in) begin
      sync1 <= {dp_in, dm_in, gp_pin_in, cs_pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
   end
   logic dp_s, dm_s, line_toggle;
   logic [NPIN-1:0] pin_s, pin_q;
   assign dp_s = sync2[NPIN+1];
   assign dm_s = sync2[NPIN];
   assign pin_s = sync2[NPIN-1:0];
   assign pin_q = sync3[NPIN-1:0];
   assign line_toggle = (sync2[NPIN+1:NPIN] != sync3[NPIN+1:NPIN]);

   // bus reset detector
   upis_line_t line_st, next_line_st;
   logic [11:0] se0_cnt, next_se0_cnt;
   logic se0, busrst_seen_ev, busrst_end_ev;
   assign se0 = !dp_s && !dm_s;
   always_comb begin
      next_line_st = line_st;
      next_se0_cnt = se0_cnt;
      busrst_seen_ev = 1'b0;
      busrst_end_ev = 1'b0;
      unique case (line_st)
         UPIS_LINE_IDLE: begin
            next_se0_cnt = 12'h000;
            if (se0) begin
               next_line_st = UPIS_LINE_SE0;
            end
         end
         UPIS_LINE_SE0: begin
            if (!se0) begin
               next_line_st = UPIS_LINE_IDLE;
            end else if (se0_cnt == 12'(SE0_CYC - 2)) begin
               next_line_st = UPIS_LINE_RESET;
               busrst_seen_ev = 1'b1;
            end else begin
               next_se0_cnt = se0_cnt + 12'h001;
            end
         end
         UPIS_LINE_RESET: begin
            if (!se0) begin
               next_line_st = UPIS_LINE_IDLE;
               busrst_end_ev = 1'b1;
            end
         end
         default: next_line_st = UPIS_LINE_IDLE;
      endcase
   end

   // periodic timers
   logic [17:0] t128_cnt, next_t128_cnt;
   logic [17:0] t1024_cnt, next_t1024_cnt;
   logic t128_ev, t1024_ev;
   always_comb begin
      t128_ev = (t128_cnt == 18'(T128_CYC - 1));
      t1024_ev = (t1024_cnt == 18'(T1024_CYC - 1));
      next_t128_cnt = t128_ev ? 18'h00000 : t128_cnt + 18'h00001;
      next_t1024_cnt = t1024_ev ? 18'h00000 : t1024_cnt + 18'h00001;
   end

   // pin edge detection with lockout; pins 0..7 current-sink, 8..23 general
   upis_regs_t r, next_r;
   logic [NPIN-1:0] pol_all, en_all, edge_all, trig_lvl, lock, next_lock;
   assign pol_all = {{8{r.gp_pol[1]}}, {8{r.gp_pol[0]}}, r.cs_pol};
   assign en_all = {r.gp_en, r.cs_en};
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         assign trig_lvl[gi] = (pin_s[gi] == pol_all[gi]);
         // positive polarity: rising edge, negative: falling edge
         assign edge_all[gi] = en_all[gi] && trig_lvl[gi] && (pin_q[gi] != pin_s[gi]);
      end
   endgenerate
   logic cs_ev, gp_ev;
   always_comb begin
      // a locked pin holds its group until it leaves its trigger level or it is disabled
      next_lock = lock & trig_lvl & en_all;
      cs_ev = 1'b0;
      gp_ev = 1'b0;
      // all simultaneous edges count together, no pin is favoured
      if (next_lock[7:0] == 8'h00 && edge_all[7:0] != 8'h00) begin
         next_lock[7:0] = edge_all[7:0];
         cs_ev = 1'b1;
      end
      if (next_lock[23:8] == 16'h0000 && edge_all[23:8] != 16'h0000) begin
         next_lock[23:8] = edge_all[23:8];
         gp_ev = 1'b1;
      end
   end

   // interrupt request and vector
   logic [9:0] req, ack_clr;
   logic [3:0] next_vec;
   assign req = r.pending & r.int_en;
   always_comb begin
      next_vec = 4'h0;
      // the source being acknowledged is left out so the vector never lags a cycle
      for (int i = 9; i >= 0; i--) begin
         if (req[i] && !ack_clr[i]) begin
            next_vec = (i >= `UPIS_SRC_CS) ? 4'(i + 2) : 4'(i + 1);
         end
      end
   end
   always_comb begin
      ack_clr = 10'h000;
      for (int i = 0; i < 10; i++) begin
         if (irq_ack_in && irq_req_out && irq_vector_out == ((i >= 8) ? 4'(i + 2) : 4'(i + 1))) begin
            ack_clr[i] = 1'b1;
         end
      end
   end

   // register file and bus slave
   logic [7:0] idx;
   logic acc_rd, acc_wr;
   logic [31:0] rd_val;
   logic [7:0] wd;
   logic [9:0] events, next_pend;
   assign idx = avs_address_in[9:2];
   assign acc_rd = avs_read_in && !avs_waitrequest_out;
   assign acc_wr = avs_write_in && !avs_waitrequest_out;
   assign wd = avs_writedata_in[7:0];
   always_comb begin
      events = {gp_ev, cs_ev,
                ep_in_host_ack_in | ep_out_dev_ack_in,
                t1024_ev, t128_ev, busrst_end_ev};
      next_r = r;
      next_pend = r.pending & ~ack_clr;
      if (acc_wr && idx == `UPIS_IDX_PENDING && avs_byteenable_in[1:0] == 2'h3) begin
         next_pend = next_pend & ~avs_writedata_in[9:0];
      end
      next_r.pending = next_pend | events;
      if (acc_wr && avs_byteenable_in[0]) begin
         unique case (idx)
            `UPIS_IDX_ADDR_A: next_r.addr_a = wd;
            `UPIS_IDX_ADDR_B: next_r.addr_b = wd;
            `UPIS_IDX_PORT_SC: begin
               next_r.port_sc[7:6] = wd[7:6];
               next_r.port_sc[`UPIS_SC_ACT_BIT] = wd[`UPIS_SC_ACT_BIT];
               next_r.port_sc[2:0] = wd[2:0];
            end
            `UPIS_IDX_INT_EN: begin
               if (avs_byteenable_in[1]) begin
                  next_r.int_en = avs_writedata_in[9:0];
               end
            end
            `UPIS_IDX_PROC_SC: begin
               if (wd[`UPIS_PROC_BUSRST_BIT]) begin
                  next_r.busrst_seen = 1'b0;
               end
            end
            `UPIS_IDX_CS_EN: next_r.cs_en = wd;
            `UPIS_IDX_CS_POL: next_r.cs_pol = wd;
            `UPIS_IDX_GP_EN: begin
               if (avs_byteenable_in[1]) begin
                  next_r.gp_en = avs_writedata_in[15:0];
               end
            end
            `UPIS_IDX_GP_POL: next_r.gp_pol = wd[1:0];
            default: ;
         endcase
      end
      // hardware sets override a same-cycle software write
      next_r.port_sc[`UPIS_SC_DP_BIT] = dp_s;
      next_r.port_sc[`UPIS_SC_DM_BIT] = dm_s;
      if (line_toggle) begin
         next_r.port_sc[`UPIS_SC_ACT_BIT] = 1'b1;
      end
      if (busrst_seen_ev) begin
         next_r.busrst_seen = 1'b1;
         next_r.addr_a = 8'h00;
         next_r.addr_b = 8'h00;
      end
   end
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (idx)
         `UPIS_IDX_ADDR_A: rd_val[7:0] = r.addr_a;
         `UPIS_IDX_ADDR_B: rd_val[7:0] = r.addr_b;
         `UPIS_IDX_PORT_SC: rd_val[7:0] = r.port_sc;
         `UPIS_IDX_INT_EN: rd_val[9:0] = r.int_en;
         `UPIS_IDX_PENDING: rd_val[9:0] = r.pending;
         `UPIS_IDX_PROC_SC: rd_val[`UPIS_PROC_BUSRST_BIT] = r.busrst_seen;
         `UPIS_IDX_CS_EN: rd_val[7:0] = r.cs_en;
         `UPIS_IDX_CS_POL: rd_val[7:0] = r.cs_pol;
         `UPIS_IDX_GP_EN: rd_val[15:0] = r.gp_en;
         `UPIS_IDX_GP_POL: rd_val[1:0] = r.gp_pol;
         `UPIS_IDX_PINS: rd_val[23:0] = pin_s;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // upstream drivers; code 000 hands the lines to the engine
   upis_pin_t next_dp, next_dm;
   always_comb begin
      next_dp = '{drive: 1'b0, enable: 1'b1};
      next_dm = '{drive: 1'b0, enable: 1'b1};
      unique case (r.port_sc[2:0])
         3'h0: begin
            next_dp = '{drive: sie_dp_in, enable: sie_oe_in};
            next_dm = '{drive: sie_dm_in, enable: sie_oe_in};
         end
         3'h1: next_dp.drive = 1'b1;
         3'h2: next_dm.drive = 1'b1;
         3'h3, 3'h4: ;
         3'h5: next_dp.enable = 1'b0;
         3'h6: next_dm.enable = 1'b0;
         3'h7: begin
            next_dp.enable = 1'b0;
            next_dm.enable = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         line_st <= UPIS_LINE_IDLE;
         se0_cnt <= 12'h000;
         t128_cnt <= 18'h00000;
         t1024_cnt <= 18'h00000;
         lock <= '0;
         r <= '0;
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
         {dp_out, dp_oe_out, dm_out, dm_oe_out} <= 4'h0;
         startup_abort_out <= 1'b0;
         irq_req_out <= 1'b0;
         irq_vector_out <= 4'h0;
      end else begin
         line_st <= next_line_st;
         se0_cnt <= next_se0_cnt;
         t128_cnt <= next_t128_cnt;
         t1024_cnt <= next_t1024_cnt;
         lock <= next_lock;
         r <= next_r;
         // one wait cycle, then one ready cycle per request
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
         avs_readdata_out <= rd_val;
         {dp_out, dp_oe_out} <= next_dp;
         {dm_out, dm_oe_out} <= next_dm;
         startup_abort_out <= busrst_seen_ev && startup_active_in;
         irq_req_out <= (req & ~ack_clr) != 10'h000;
         irq_vector_out <= next_vec;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_se0_full;
      se0 && line_st == UPIS_LINE_SE0 && se0_cnt == 12'(SE0_CYC - 2);
   endsequence
   chk_busrst_recog: assert property (s_se0_full |=> r.busrst_seen && r.addr_a == 8'h00)
      else $error("bus reset not recognised at threshold");
   chk_se0_def: assert property ((dp_s || dm_s) |=> line_st != UPIS_LINE_RESET || $past(line_st) == UPIS_LINE_RESET)
      else $error("reset entered without both lines low");
   chk_busrst_irq: assert property ((line_st == UPIS_LINE_RESET && !se0) |=> r.pending[0])
      else $error("bus reset interrupt missing at SE0 end");
   chk_no_early_irq: assert property ((line_st == UPIS_LINE_RESET && se0 && !r.pending[0] && !$past(r.pending[0])) |=> !r.pending[0] || ack_clr[0])
      else $error("bus reset interrupt raised during SE0");
   chk_startup_abort: assert property ((busrst_seen_ev && startup_active_in) |=> startup_abort_out)
      else $error("start-up delay not aborted");
   chk_ep_pending: assert property ((ep_in_host_ack_in[0] || ep_out_dev_ack_in[0]) |=> r.pending[3])
      else $error("endpoint 0 interrupt not latched");
   chk_t128_period: assert property (t128_ev |=> r.pending[1] ##0 !t128_ev [*8])
      else $error("128 us tick not latched");
   chk_cs_lock: assert property (((lock[7:0] & trig_lvl[7:0] & en_all[7:0]) != 8'h00) |-> !cs_ev)
      else $error("current-sink interrupt during lockout");
   chk_gp_lock: assert property (((lock[23:8] & trig_lvl[23:8] & en_all[23:8]) != 16'h0000) |-> !gp_ev)
      else $error("general pin interrupt during lockout");
   chk_se0_force: assert property ((r.port_sc[2:0] == 3'h3) |=> !dp_out && dp_oe_out && !dm_out && dm_oe_out)
      else $error("forced SE0 not driven");
   chk_prio_order: assert property ((req[0] && !ack_clr[0]) |=> irq_vector_out == 4'h1 && irq_req_out)
      else $error("bus reset lost priority");
   chk_sc_pins: assert property (!rst_in |=> r.port_sc[`UPIS_SC_DP_BIT] == $past(dp_s))
      else $error("D+ status bit stale");
endmodule : upis_top
`default_nettype wire

// *** testbench/upis_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module upis_host_model (
   input wire logic clk_in,
   output logic dp_out,
   output logic dm_out,
   output logic [4:0] in_ack_out,
   output logic [4:0] out_ack_out
);
   // idle J between events: the device pull-up keeps D+ high
   initial begin
      dp_out = 1'b1;
      dm_out = 1'b0;
      in_ack_out = '0;
      out_ack_out = '0;
   end

   task automatic bus_reset(input int n);
      @(posedge clk_in);
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      dp_out <= 1'b1;
   endtask : bus_reset

   // dir 0: host acknowledge of an IN; dir 1: engine acknowledge of an OUT
   task automatic ack_pulse(input logic dir, input int e);
      @(posedge clk_in);
      if (dir) out_ack_out[e] <= 1'b1;
      else in_ack_out[e] <= 1'b1;
      @(posedge clk_in);
      // only its own bit is lowered, so two pulses in parallel never drive one signal twice
      if (dir) out_ack_out[e] <= 1'b0;
      else in_ack_out[e] <= 1'b0;
   endtask : ack_pulse
endmodule : upis_host_model
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "upis_regs.svh"
module tb;
   import upis_pkg::*;
   localparam int P128 = 40;
   localparam int P1024 = 100;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [9:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_wdata = '0;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic dp_out, dp_oe_out, dm_out, dm_oe_out, h_dp, h_dm;
   logic sie_dp = 1'b0;
   logic sie_dm = 1'b0;
   logic sie_oe = 1'b0;
   logic [4:0] in_ack, out_ack;
   logic [7:0] cs_pin = 8'h02;
   logic [15:0] gp_pin = 16'h0100;
   logic startup = 1'b0;
   logic irq_ack = 1'b0;
   logic irq_req_out, startup_abort_out;
   logic [3:0] irq_vector_out;
   wire logic dp_wire, dm_wire;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_abort = 0;
   logic [31:0] rnd = 32'h0ed5;
   logic [31:0] rd;
   logic [31:0] mdl [int];
   logic [3:0] drv_tab [8] = '{4'h0, 4'he, 4'hb, 4'ha, 4'ha, 4'h2, 4'h8, 4'h0};

   // the pad level is the device's while it drives, the host's otherwise
   assign dp_wire = (dp_oe_out === 1'b1) ? dp_out : h_dp;
   assign dm_wire = (dm_oe_out === 1'b1) ? dm_out : h_dm;

   upis_top #(.T128_CYC(P128), .T1024_CYC(P1024)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
      .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .dp_in(dp_wire), .dm_in(dm_wire),
      .dp_out(dp_out), .dp_oe_out(dp_oe_out), .dm_out(dm_out), .dm_oe_out(dm_oe_out),
      .sie_dp_in(sie_dp), .sie_dm_in(sie_dm), .sie_oe_in(sie_oe),
      .ep_in_host_ack_in(in_ack), .ep_out_dev_ack_in(out_ack), .cs_pin_in(cs_pin),
      .gp_pin_in(gp_pin), .startup_active_in(startup), .startup_abort_out(startup_abort_out),
      .irq_ack_in(irq_ack), .irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out)
   );
   upis_host_model u_host (
      .clk_in(clk_in), .dp_out(h_dp), .dm_out(h_dm), .in_ack_out(in_ack),
      .out_ack_out(out_ack)
   );

   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (startup_abort_out === 1'b1) n_abort <= n_abort + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // waitrequest and read data are taken at the rising edge where waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      avs_address <= {idx, 2'b00};
      avs_wdata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 50);
      if (avs_waitrequest_out !== 1'b0) begin
         bad_count++;
         give_verdict();
      end
      rd = avs_readdata_out;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] m,
                         input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(nm, rd & m, exp);
   endtask : rd_chk

   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (irq_req_out !== 1'b1 && n < lim);
      chk("irq_req", irq_req_out, 32'h1);
      if (irq_req_out !== 1'b1) give_verdict();
   endtask : wait_irq

   task automatic service;
      @(posedge clk_in);
      irq_ack <= 1'b1;
      @(posedge clk_in);
      irq_ack <= 1'b0;
      repeat (2) @(posedge clk_in);
   endtask : service

   task automatic period(input int src, input int per);
      int t0;
      bus(1'b1, `UPIS_IDX_INT_EN, 32'h1 << src);
      // the first request may stem from a tick latched long ago; only later ones are timed
      wait_irq(400);
      service();
      wait_irq(400);
      t0 = cyc;
      chk("timer vector", irq_vector_out, src + 1);
      service();
      wait_irq(400);
      chk("timer period", cyc - t0, per);
      service();
   endtask : period

   task automatic set_pin(input int g, input int k, input logic v);
      @(posedge clk_in);
      if (g == 0) cs_pin[k] <= v;
      else gp_pin[k * 8] <= v;
   endtask : set_pin

   task automatic pin_lock(input int g);
      logic [7:0] en_idx;
      en_idx = g ? `UPIS_IDX_GP_EN : `UPIS_IDX_CS_EN;
      bus(1'b1, en_idx, mdl[g]);
      bus(1'b1, `UPIS_IDX_INT_EN, 32'h100 << g);
      bus(1'b1, `UPIS_IDX_PENDING, 32'h3ff);
      set_pin(g, 0, 1'b1);
      wait_irq(20);
      chk("pin vector", irq_vector_out, 10 + g);
      service();
      rd_chk("pins", `UPIS_IDX_PINS, 32'hffffff, {8'h00, gp_pin, cs_pin});
      rd_chk("pin enable", en_idx, 32'hffff, mdl[g]);
      set_pin(g, 1, 1'b0);
      repeat (20) @(negedge clk_in);
      chk("locked out", irq_req_out, 32'h0);
      set_pin(g, 0, 1'b0);
      set_pin(g, 1, 1'b1);
      repeat (6) @(posedge clk_in);
      set_pin(g, 1, 1'b0);
      wait_irq(20);
      chk("pin vector", irq_vector_out, 10 + g);
      service();
   endtask : pin_lock

   initial begin
      repeat (100000) @(posedge clk_in);
      bad_count++;
      give_verdict();
   end

   initial begin
      mdl[0] = 32'h03;
      mdl[1] = 32'h0101;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_chk("port sc reset", `UPIS_IDX_PORT_SC, 32'hcf, 32'h0);
      rnd = lfsr(rnd);
      mdl[2] = {24'h0, rnd[7:0]};
      mdl[3] = {24'h0, rnd[15:8]};
      bus(1'b1, `UPIS_IDX_ADDR_A, mdl[2]);
      bus(1'b1, `UPIS_IDX_ADDR_B, mdl[3]);
      rd_chk("addr a", `UPIS_IDX_ADDR_A, 32'hff, mdl[2]);
      rd_chk("addr b", `UPIS_IDX_ADDR_B, 32'hff, mdl[3]);
      rd_chk("unmapped", 8'h3f, 32'hffffffff, 32'h0);
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         sie_dp <= rnd[0];
         sie_dm <= rnd[1];
         sie_oe <= rnd[2];
         bus(1'b1, `UPIS_IDX_PORT_SC, k);
         repeat (3) @(posedge clk_in);
         chk("drivers", {dp_oe_out, dp_out & dp_oe_out, dm_oe_out, dm_out & dm_oe_out},
             (k == 0) ? {rnd[2], rnd[0] & rnd[2], rnd[2], rnd[1] & rnd[2]} : drv_tab[k]);
      end
      sie_oe <= 1'b0;
      bus(1'b1, `UPIS_IDX_PORT_SC, 32'h0);
      rd_chk("line levels", `UPIS_IDX_PORT_SC, 32'h30, 32'h20);
      startup <= 1'b1;
      u_host.bus_reset(2000);
      repeat (5) @(posedge clk_in);
      rd_chk("short se0", `UPIS_IDX_PROC_SC, 32'h20, 32'h0);
      chk("short abort", n_abort, 32'h0);
      fork
         u_host.bus_reset(3300);
         begin
            repeat (3000) @(posedge clk_in);
            rd_chk("irq during se0", `UPIS_IDX_PENDING, 32'h1, 32'h0);
            rd_chk("se0 lines", `UPIS_IDX_PORT_SC, 32'h30, 32'h0);
         end
      join
      repeat (10) @(posedge clk_in);
      startup <= 1'b0;
      rd_chk("irq after se0", `UPIS_IDX_PENDING, 32'h1, 32'h1);
      rd_chk("reset seen", `UPIS_IDX_PROC_SC, 32'h20, 32'h20);
      rd_chk("addr a cleared", `UPIS_IDX_ADDR_A, 32'hff, 32'h0);
      rd_chk("addr b cleared", `UPIS_IDX_ADDR_B, 32'hff, 32'h0);
      chk("abort", n_abort, 32'h1);
      bus(1'b1, `UPIS_IDX_INT_EN, 32'h1);
      wait_irq(10);
      chk("reset vector", irq_vector_out, 32'h1);
      service();
      bus(1'b1, `UPIS_IDX_PROC_SC, 32'h20);
      rd_chk("reset seen cleared", `UPIS_IDX_PROC_SC, 32'h20, 32'h0);
      period(1, P128);
      period(2, P1024);
      bus(1'b1, `UPIS_IDX_INT_EN, 32'hf8);
      for (int e = 0; e < 5; e++) begin
         for (int d = 0; d < 2; d++) begin
            u_host.ack_pulse(d[0], e);
            wait_irq(20);
            chk("ep vector", irq_vector_out, e + 4);
            service();
         end
      end
      repeat (20) @(negedge clk_in);
      chk("no ack no irq", irq_req_out, 32'h0);
      fork
         u_host.ack_pulse(1'b0, 4);
         u_host.ack_pulse(1'b1, 1);
      join
      wait_irq(20);
      chk("first vector", irq_vector_out, 32'h5);
      service();
      wait_irq(20);
      chk("second vector", irq_vector_out, 32'h8);
      service();
      bus(1'b1, `UPIS_IDX_CS_POL, 32'h1);
      bus(1'b1, `UPIS_IDX_GP_POL, 32'h1);
      pin_lock(0);
      pin_lock(1);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
